/* File: bench/cpurf_core_props.sv */
// Purpose: Port timing checks for the core register file.
// Assumes: Bench keeps control and bus writes apart from checked events.
// Notes:   Bound to every instance of the core.
`timescale 1ns/100ps
module cpurf_core_props (
    input wire logic        sys_clk, sys_rst, gpr_wr_en, ctl_wr_en, pc_load,
    input wire logic        fast_int_take, fast_int_return, fexc_valid,
    input wire logic        float_trap, s_axi_wvalid,
    input wire logic [3:0]  gpr_wr_idx,
    input wire logic [4:0]  fexc_flags,
    input wire logic [31:0] gpr_wr_data, pc_next, program_counter,
    input wire logic [31:0] processor_status_word, float_status_word,
    input wire logic [31:0] active_stack_ptr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Float flags split by their enable bits
    wire logic [4:0] hit = fexc_flags & float_status_word[9:5];
    wire logic [4:0] miss = fexc_flags & ~float_status_word[9:5];
    wire logic [4:0] acc = float_status_word[14:10];
    a_pc_load: assert property (pc_load && !fast_int_take
        && !fast_int_return |=> program_counter == $past(pc_next))
        else $error("pc load lost");
    a_ret_pc: assert property (fast_int_take ##1 fast_int_return
        |=> program_counter == $past(program_counter, 2))
        else $error("pc not restored");
    a_ret_psw: assert property (fast_int_take ##1 fast_int_return
        |=> processor_status_word == $past(processor_status_word, 2))
        else $error("status word not restored");
    a_trap_on: assert property (fexc_valid && hit != 5'h0
        |=> float_trap && float_status_word[4:0] == $past(hit))
        else $error("trap or cause wrong");
    a_trap_off: assert property (!(fexc_valid && hit != 5'h0)
        |=> !float_trap) else $error("stray trap");
    a_accum_set: assert property (fexc_valid
        |=> (acc & $past(miss)) == $past(miss)) else $error("accum not set");
    a_accum_hold: assert property (!ctl_wr_en && !s_axi_wvalid
        && !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2)
        |=> (acc & $past(acc)) == $past(acc)) else $error("accum lost");
    a_sp_write: assert property (gpr_wr_en && gpr_wr_idx == 4'h0
        && !ctl_wr_en && !fast_int_take && !fast_int_return
        |=> active_stack_ptr == $past(gpr_wr_data)) else $error("sp write lost");
endmodule // cpurf_core_props
bind cpurf_core cpurf_core_props props_u (.*);

/* File: bench/cpurf_core_tb.sv */
// Purpose: Self-checking bench for the core register file.
// Assumes: Inputs change by non-blocking assignment after a rising edge.
// Notes:   Array m mirrors the register map by word index.
`timescale 1ns/100ps
module cpurf_core_tb
    import cpurf_pkg::*;
;
    logic sys_clk, sys_rst, gpr_wr_en, ctl_wr_en, pc_load, fexc_valid, fint;
    logic slow, fast_int_take, fast_int_return, float_trap, irq, s_axi_rready;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] ctl_wr_sel;
    logic [3:0] rd_a_idx, rd_b_idx, gpr_wr_idx, s_axi_wstrb;
    logic [4:0] fexc_flags;
    logic [31:0] rd_a_data, rd_b_data, gpr_wr_data, ctl_wr_data, pc_next;
    logic [31:0] program_counter, processor_status_word, vector_table_base;
    logic [31:0] float_status_word, active_stack_ptr, s_axi_awaddr, v, p;
    logic [31:0] s_axi_wdata, s_axi_araddr, s_axi_rdata, m [0:26];
    int seed = 32'h2b87;
    int bad_count = 0;
    int comparisons = 0;
    cpurf_core dut_u (.*);
    cpurf_pipe_model pipe_u (.*);
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One bus write or read; d is write data or expected read data
    task automatic bus(input logic w, input logic [31:0] a, d, input int er);
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= {a, d, a};
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
        {s_axi_bready, s_axi_rready} <= {w, !w};
        do begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid));
        chk(w ? s_axi_bresp : s_axi_rresp, er);
        if (!w) chk(s_axi_rdata, d);
    endtask
    initial begin
        {sys_clk, gpr_wr_en, ctl_wr_en, pc_load, fexc_valid, fint, slow} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, ctl_wr_sel, rd_a_idx, rd_b_idx, gpr_wr_idx} = '0;
        {fexc_flags, gpr_wr_data, ctl_wr_data, pc_next} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        sys_rst = 1'b1;
        m = '{default: '0};
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // Reset values, unmapped read, then fill every writable word but the interrupt status and read all back
        for (int i = 0; i < 28; i++) bus(0, i * 4, 0, i < 27 ? 0 : 2);
        for (int i = 0; i < 28; i++) begin
            v = (i == 26) ? 32'hf : $random(seed) & 32'hffff_fffc;
            if (i == 25) continue;
            bus(1, i * 4, v, (i == 19 || i == 27) ? 2 : 0);
            if (i != 19 && i != 27)
                m[i ? i : 16 + m[20][17]] = i == 24 ? v & FSW_MASK : v;
        end
        for (int i = 0; i < 27; i++)
            bus(0, i * 4, i ? m[i] : m[16 + m[20][17]], 0);
        chk(vector_table_base, m[18]);
        // Pipeline stack write, then flip the stack select bit
        v = $random(seed) & 32'hffff_fffc;
        {gpr_wr_en, gpr_wr_data} <= {1'b1, v};
        @(posedge sys_clk);
        m[16 + m[20][17]] = v;
        {gpr_wr_en, ctl_wr_en, ctl_wr_sel} <= {1'b0, 1'b1, CTL_STW};
        ctl_wr_data <= m[20] ^ 32'h2_0000;
        @(posedge sys_clk);
        m[20] = m[20] ^ 32'h2_0000;
        ctl_wr_en <= 1'b0;
        chk(active_stack_ptr, v);
        @(posedge sys_clk);
        chk(active_stack_ptr, m[16 + m[20][17]]);
        chk(rd_a_data, v);
        chk(rd_b_data, v);
        // Fast interrupt, slow handler first, then prompt return
        for (int s = 1; s >= 0; s--) begin
            p = $random(seed) & 32'hffff_fffc;
            {pc_load, pc_next} <= {1'b1, p};
            @(posedge sys_clk);
            {pc_load, fint, slow} <= {1'b0, 1'b1, s[0]};
            @(posedge sys_clk);
            fint <= 1'b0;
            repeat (2) @(posedge sys_clk);
            chk(program_counter, m[23]);
            repeat (4) @(posedge sys_clk);
            chk(program_counter, p);
            chk(irq, 1'b1);
            bus(0, 32'h54, p, 0);
            bus(0, 32'h58, m[20], 0);
            bus(0, 32'h64, 32'h1, 0);
            repeat (2) @(posedge sys_clk);
            chk(irq, 1'b0);
        end
        // Float events with two of five enabled, float bits masked
        bus(1, 32'h68, 32'h1, 0);
        {ctl_wr_en, ctl_wr_sel, ctl_wr_data} <= {1'b1, CTL_FSW, 32'h60};
        m[24] = 32'h60;
        for (int j = 0; j < 5; j++) begin
            @(posedge sys_clk);
            {ctl_wr_en, fexc_valid, fexc_flags} <= {2'b01, 5'h1 << j};
            @(posedge sys_clk);
            fexc_valid <= 1'b0;
            @(posedge sys_clk);
            chk(float_trap, j < 2);
            m[24] = j < 2 ? {m[24][31:5], 5'h1 << j} : m[24] | 32'h400 << j;
        end
        chk(float_status_word, m[24]);
        chk(irq, 1'b0);
        bus(0, 32'h64, 32'h6, 0);
        bus(1, 32'h60, 0, 0);
        repeat (2) @(posedge sys_clk);
        chk(float_status_word, 32'h0);
        end_of_test();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (4000) @(posedge sys_clk);
        bad_count++;
        end_of_test();
    end
endmodule // cpurf_core_tb

/* File: bench/cpurf_pipe_model.sv */
// Purpose: Pipeline side model raising fast interrupt entry and return.
// Assumes: fint is a one-cycle request.
// Notes:   Return follows entry by one cycle, or by four when slow.
`timescale 1ns/100ps
module cpurf_pipe_model (
    input  wire logic sys_clk, sys_rst, fint, slow,
    output logic      fast_int_take, fast_int_return
);
    logic [2:0] cnt;
    // Entry pulse, handler length count, then return pulse
    always_ff @(posedge sys_clk) begin
        fast_int_take <= !sys_rst && fint && cnt == 3'h0;
        fast_int_return <= !sys_rst && cnt == 3'h1;
        cnt <= sys_rst ? 3'h0 : (fint && cnt == 3'h0) ? (slow ? 3'h4 : 3'h1)
            : cnt - {2'h0, cnt != 3'h0};
    end
endmodule // cpurf_pipe_model

/* File: src/cpurf_axil.sv */
// Purpose: AXI4-Lite slave front end for the core register file.
// Assumes: One write and one read outstanding; 32-bit data.
// Notes:   Unmapped targets and program counter writes answer SLVERR; interrupt status writes answer OKAY and are ignored.
`timescale 1ns/100ps
module cpurf_axil
    import cpurf_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic [31:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [31:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   bus_wr,
    output logic [IDX_W-1:0]       bus_widx,
    output logic [31:0]            bus_wdata,
    output logic [3:0]             bus_wstrb,
    output logic                   bus_rd,
    output logic [IDX_W-1:0]       bus_ridx,
    input  wire logic [31:0]       bus_rdata
);

    typedef struct packed {
        logic              aw_full;
        logic [31:0]       awaddr;
        logic              w_full;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } cpurf_axil_t;

    cpurf_axil_t s;
    cpurf_axil_t next_s;
    logic        w_mapped;
    logic        r_mapped;

    // Handshake and address decode
    always_comb begin
        s_axi_awready = !s.aw_full;
        s_axi_wready  = !s.w_full;
        s_axi_arready = !s.rvalid;
        w_mapped  = (s.awaddr[31:8] == 24'h0) &&
                    idx_wr_ok(s.awaddr[7:2]);
        r_mapped  = (s_axi_araddr[31:8] == 24'h0) &&
                    idx_rd_ok(s_axi_araddr[7:2]);
        bus_widx  = s.awaddr[7:2];
        bus_wdata = s.wdata;
        bus_wstrb = s.wstrb;
        bus_ridx  = s_axi_araddr[7:2];
        bus_wr    = s.aw_full && s.w_full && !s.bvalid && w_mapped;
        bus_rd    = s_axi_arvalid && !s.rvalid && r_mapped;
    end

    // Next state of both channels
    always_comb begin
        next_s = s;
        if (s_axi_awvalid && !s.aw_full) begin
            next_s.aw_full = 1'b1;
            next_s.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_full) begin
            next_s.w_full = 1'b1;
            next_s.wdata  = s_axi_wdata;
            next_s.wstrb  = s_axi_wstrb;
        end
        if (s.aw_full && s.w_full && !s.bvalid) begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = w_mapped ? RESP_OK : RESP_ERR;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = r_mapped ? bus_rdata : RST_WORD;
            next_s.rresp  = r_mapped ? RESP_OK : RESP_ERR;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp  = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata  = s.rdata;
    assign s_axi_rresp  = s.rresp;

endmodule // cpurf_axil

/* File: src/cpurf_core.sv */
// Purpose: Core register file with control registers and float status.
// Assumes: Pipeline signals are on sys_clk; pulses last one cycle.
// Notes:   Core writes take priority over bus writes in the same cycle.
//          Status reads clear the sticky bits; new events win.
//          Misaligned pointer loads by control transfer, or over the bus with no aligned control pointer load in the same cycle, raise a status bit.
//
// Summary of operation
// - Sixteen general registers; one to fifteen hold data or addresses.
// - Register zero is the selected stack pointer.
// - Status word bit picks interrupt or user stack pointer.
// - Vector table base holds table start, loaded with multiples of four.
// - Program counter holds the executing instruction's address.
// - Fast interrupt saves program counter to its backup.
// - Fast interrupt saves status word to its same-layout backup.
// - Fast interrupt branches to the fast vector address.
// - Enabled float exceptions trap and set their cause flag.
// - Disabled float exceptions set their accumulated flag, no trap.
// - Accumulated float flags stay set until software writes zero.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module cpurf_core
    import cpurf_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic [3:0]   rd_a_idx,
    output logic [31:0]       rd_a_data,
    input  wire logic [3:0]   rd_b_idx,
    output logic [31:0]       rd_b_data,
    input  wire logic         gpr_wr_en,
    input  wire logic [3:0]   gpr_wr_idx,
    input  wire logic [31:0]  gpr_wr_data,
    input  wire logic         ctl_wr_en,
    input  wire logic [2:0]   ctl_wr_sel,
    input  wire logic [31:0]  ctl_wr_data,
    input  wire logic         pc_load,
    input  wire logic [31:0]  pc_next,
    input  wire logic         fast_int_take,
    input  wire logic         fast_int_return,
    input  wire logic         fexc_valid,
    input  wire logic [4:0]   fexc_flags,
    output logic [31:0]       program_counter,
    output logic [31:0]       processor_status_word,
    output logic [31:0]       vector_table_base,
    output logic [31:0]       float_status_word,
    output logic [31:0]       active_stack_ptr,
    output logic              float_trap,
    output logic              irq,
    input  wire logic [31:0]  s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [31:0]  s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready
);

    typedef struct packed {
        logic [15:0][31:0] gpr;
        logic [31:0]       interrupt_stack_ptr;
        logic [31:0]       user_stack_ptr;
        logic [31:0]       vector_table_base;
        logic [31:0]       program_counter;
        logic [31:0]       processor_status_word;
        logic [31:0]       backup_program_counter;
        logic [31:0]       backup_status_word;
        logic [31:0]       fast_vector_register;
        logic [31:0]       float_status_word;
        logic [EV_W-1:0]   irq_status;
        logic [EV_W-1:0]   irq_mask;
        logic [31:0]       rd_a;
        logic [31:0]       rd_b;
        logic              float_trap;
    } cpurf_state_t;

    cpurf_state_t s;
    cpurf_state_t next_s;

    logic              bus_wr;
    logic [IDX_W-1:0]  bus_widx;
    logic [31:0]       bus_wdata;
    logic [3:0]        bus_wstrb;
    logic              bus_rd;
    logic [IDX_W-1:0]  bus_ridx;
    logic [31:0]       bus_rdata;

    // Stack pointer currently selected by the status word
    function automatic logic [31:0] sp_sel(input cpurf_state_t st);
        return st.processor_status_word[STW_U_BIT] ?
               st.user_stack_ptr : st.interrupt_stack_ptr;
    endfunction

    // General register read; index zero yields the active stack pointer
    function automatic logic [31:0] gpr_read(input cpurf_state_t st,
                                             input logic [3:0] i);
        return (i == 4'h0) ? sp_sel(st) : st.gpr[i];
    endfunction

    // Byte-lane merge of a bus write
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Float status write keeping only defined fields
    function automatic logic [31:0] fsw_fix(input logic [31:0] v);
        return v & FSW_MASK;
    endfunction

    // Bus slave front end
    cpurf_axil u_axil (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .bus_wr        (bus_wr),
        .bus_widx      (bus_widx),
        .bus_wdata     (bus_wdata),
        .bus_wstrb     (bus_wstrb),
        .bus_rd        (bus_rd),
        .bus_ridx      (bus_ridx),
        .bus_rdata     (bus_rdata)
    );

    // Bus read mux; index zero reads the active stack pointer
    always_comb begin
        bus_rdata = (bus_ridx <= IDX_GPR15) ? gpr_read(s, bus_ridx[3:0])
                                            : bus_rdata_w(bus_ridx);
    end

    // Next state: bus writes first, core activity overrides
    always_comb begin
        logic [EV_W-1:0]   ev;
        logic [31:0]       bv;
        logic [FEXC_W-1:0] en;
        logic [FEXC_W-1:0] trap_set;
        logic [FEXC_W-1:0] acc_set;
        ev       = '0;
        bv       = RST_WORD;
        en       = s.float_status_word[FSW_ENABLE +: FEXC_W];
        trap_set = '0;
        acc_set  = '0;
        next_s   = s;
        next_s.float_trap = 1'b0;

        // Software access over the bus
        if (bus_wr) begin
            if (bus_widx <= IDX_GPR15) begin
                bv = lane_merge(gpr_read(s, bus_widx[3:0]), bus_wdata,
                                bus_wstrb);
            end else begin
                bv = lane_merge(bus_rdata_w(bus_widx), bus_wdata,
                                bus_wstrb);
            end
            if (bus_widx == IDX_GPR0) begin
                if (s.processor_status_word[STW_U_BIT]) begin
                    next_s.user_stack_ptr = bv;
                end else begin
                    next_s.interrupt_stack_ptr = bv;
                end
                ev[EV_ALIGN] = |bv[1:0];
            end else if (bus_widx <= IDX_GPR15) begin
                next_s.gpr[bus_widx[3:0]] = bv;
            end else begin
                unique case (bus_widx)
                    IDX_ISTK: begin
                        next_s.interrupt_stack_ptr = bv;
                        ev[EV_ALIGN] = |bv[1:0];
                    end
                    IDX_USTK: begin
                        next_s.user_stack_ptr = bv;
                        ev[EV_ALIGN] = |bv[1:0];
                    end
                    IDX_VTB: begin
                        next_s.vector_table_base = bv;
                        ev[EV_ALIGN] = |bv[1:0];
                    end
                    IDX_STW:   next_s.processor_status_word = bv;
                    IDX_BKPC:  next_s.backup_program_counter = bv;
                    IDX_BKSW:  next_s.backup_status_word = bv;
                    IDX_FVEC:  next_s.fast_vector_register = bv;
                    IDX_FSW:   next_s.float_status_word = fsw_fix(bv);
                    IDX_MASK:  next_s.irq_mask = bv[EV_W-1:0];
                    default:   next_s.irq_mask = s.irq_mask;
                endcase
            end
        end

        // Control register transfer from the pipeline
        if (ctl_wr_en) begin
            unique case (ctl_wr_sel)
                CTL_ISTK: begin
                    next_s.interrupt_stack_ptr = ctl_wr_data;
                    ev[EV_ALIGN] = |ctl_wr_data[1:0];
                end
                CTL_USTK: begin
                    next_s.user_stack_ptr = ctl_wr_data;
                    ev[EV_ALIGN] = |ctl_wr_data[1:0];
                end
                CTL_VTB: begin
                    next_s.vector_table_base = ctl_wr_data;
                    ev[EV_ALIGN] = |ctl_wr_data[1:0];
                end
                CTL_STW:  next_s.processor_status_word = ctl_wr_data;
                CTL_BKPC: next_s.backup_program_counter = ctl_wr_data;
                CTL_BKSW: next_s.backup_status_word = ctl_wr_data;
                CTL_FVEC: next_s.fast_vector_register = ctl_wr_data;
                CTL_FSW:  next_s.float_status_word = fsw_fix(ctl_wr_data);
            endcase
        end

        // General register write; index zero reaches the active pointer
        if (gpr_wr_en) begin
            if (gpr_wr_idx == 4'h0) begin
                if (s.processor_status_word[STW_U_BIT]) begin
                    next_s.user_stack_ptr = gpr_wr_data;
                end else begin
                    next_s.interrupt_stack_ptr = gpr_wr_data;
                end
            end else begin
                next_s.gpr[gpr_wr_idx] = gpr_wr_data;
            end
        end

        // Program counter flow: fast entry, fast return, then normal step
        if (fast_int_take) begin
            next_s.backup_program_counter = s.program_counter;
            next_s.backup_status_word = s.processor_status_word;
            next_s.program_counter = s.fast_vector_register;
            ev[EV_FAST] = 1'b1;
        end else if (fast_int_return) begin
            next_s.program_counter = s.backup_program_counter;
            next_s.processor_status_word = s.backup_status_word;
        end else if (pc_load) begin
            next_s.program_counter = pc_next;
        end

        // Float exceptions: trap when enabled, accumulate when masked
        if (fexc_valid) begin
            trap_set = fexc_flags & en;
            acc_set  = fexc_flags & ~en;
        end
        if (|trap_set) begin
            next_s.float_status_word[FSW_CAUSE +: FEXC_W] = trap_set;
            next_s.float_trap = 1'b1;
            ev[EV_TRAP] = 1'b1;
        end
        // Set wins over a software clear in the same cycle
        next_s.float_status_word[FSW_ACCUM +: FEXC_W] =
            next_s.float_status_word[FSW_ACCUM +: FEXC_W] | acc_set;
        ev[EV_ACCUM] = |acc_set;

        // Sticky status: read clears, new event wins
        if (bus_rd && bus_ridx == IDX_STATUS) begin
            next_s.irq_status = '0;
        end
        next_s.irq_status = next_s.irq_status | ev;

        // Registered read ports see the state before this cycle's writes
        next_s.rd_a = gpr_read(s, rd_a_idx);
        next_s.rd_b = gpr_read(s, rd_b_idx);
    end

    // Current value of a control word by bus index
    function automatic logic [31:0] bus_rdata_w(input logic [5:0] i);
        logic [31:0] r;
        r = RST_WORD;
        unique case (i)
            IDX_ISTK:   r = s.interrupt_stack_ptr;
            IDX_USTK:   r = s.user_stack_ptr;
            IDX_VTB:    r = s.vector_table_base;
            IDX_PC:     r = s.program_counter;
            IDX_STW:    r = s.processor_status_word;
            IDX_BKPC:   r = s.backup_program_counter;
            IDX_BKSW:   r = s.backup_status_word;
            IDX_FVEC:   r = s.fast_vector_register;
            IDX_FSW:    r = s.float_status_word;
            IDX_STATUS: r = {28'h0, s.irq_status};
            IDX_MASK:   r = {28'h0, s.irq_mask};
            default:    r = RST_WORD;
        endcase
        return r;
    endfunction

    // State register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state
    assign rd_a_data             = s.rd_a;
    assign rd_b_data             = s.rd_b;
    assign program_counter       = s.program_counter;
    assign processor_status_word = s.processor_status_word;
    assign vector_table_base     = s.vector_table_base;
    assign float_status_word     = s.float_status_word;
    assign active_stack_ptr      = sp_sel(s);
    assign float_trap            = s.float_trap;
    assign irq                   = |(s.irq_status & s.irq_mask);

endmodule // cpurf_core

/* File: src/cpurf_pkg.sv */
// Purpose: Shared constants and types of the core register file.
// Assumes: 32-bit words, AXI4-Lite register window of 32-bit words.
// Notes:   Bus offsets are byte addresses; index is offset divided by 4.
package cpurf_pkg;

    localparam int unsigned XLEN  = 32;
    localparam int unsigned IDX_W = 6;

    // Bus word indices
    localparam logic [5:0] IDX_GPR0   = 6'h00;
    localparam logic [5:0] IDX_GPR15  = 6'h0f;
    localparam logic [5:0] IDX_ISTK   = 6'h10;
    localparam logic [5:0] IDX_USTK   = 6'h11;
    localparam logic [5:0] IDX_VTB    = 6'h12;
    localparam logic [5:0] IDX_PC     = 6'h13;
    localparam logic [5:0] IDX_STW    = 6'h14;
    localparam logic [5:0] IDX_BKPC   = 6'h15;
    localparam logic [5:0] IDX_BKSW   = 6'h16;
    localparam logic [5:0] IDX_FVEC   = 6'h17;
    localparam logic [5:0] IDX_FSW    = 6'h18;
    localparam logic [5:0] IDX_STATUS = 6'h19;
    localparam logic [5:0] IDX_MASK   = 6'h1a;

    // Control transfer selectors
    localparam logic [2:0] CTL_ISTK = 3'h0;
    localparam logic [2:0] CTL_USTK = 3'h1;
    localparam logic [2:0] CTL_VTB  = 3'h2;
    localparam logic [2:0] CTL_STW  = 3'h3;
    localparam logic [2:0] CTL_BKPC = 3'h4;
    localparam logic [2:0] CTL_BKSW = 3'h5;
    localparam logic [2:0] CTL_FVEC = 3'h6;
    localparam logic [2:0] CTL_FSW  = 3'h7;

    // Field positions
    localparam int unsigned STW_U_BIT  = 17;
    localparam int unsigned FSW_CAUSE  = 0;
    localparam int unsigned FSW_ENABLE = 5;
    localparam int unsigned FSW_ACCUM  = 10;
    localparam int unsigned FEXC_W     = 5;
    localparam logic [31:0] FSW_MASK   = 32'h0000_7fff;

    // Interrupt status bits
    localparam int unsigned EV_FAST  = 0;
    localparam int unsigned EV_TRAP  = 1;
    localparam int unsigned EV_ACCUM = 2;
    localparam int unsigned EV_ALIGN = 3;
    localparam int unsigned EV_W     = 4;

    // Reset value and bus response codes
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  RESP_OK  = 2'h0;
    localparam logic [1:0]  RESP_ERR = 2'h2;

    // Readable word indices
    function automatic logic idx_rd_ok(input logic [5:0] i);
        return i <= IDX_MASK;
    endfunction

    // Writable word indices: all readable ones except the program counter
    function automatic logic idx_wr_ok(input logic [5:0] i);
        return (i <= IDX_MASK) && (i != IDX_PC);
    endfunction

endpackage
